/* File: verilog/awd_defs.vh */
`ifndef AWD_DEFS_VH
`define AWD_DEFS_VH

// AXI4-Lite register byte offsets.
`define AWD_REG_CTRL 5'h00
`define AWD_REG_WORD0 5'h04
`define AWD_REG_WORD1 5'h08
`define AWD_REG_STAT 5'h0c
`define AWD_REG_FIELDS 5'h10
`define AWD_REG_OPERAND 5'h14
`define AWD_REG_LITERAL 5'h18
`define AWD_REG_PREV 5'h1c

// Control register fields and format codes.
`define AWD_CTRL_FMT_LSB 0
`define AWD_CTRL_GO_BIT 2
`define AWD_FMT_OP3 2'h0
`define AWD_FMT_LOAD 2'h1
`define AWD_FMT_EXEC 2'h2

// High doubleword field positions.
`define AWD_SEL_MSB 8
`define AWD_REL_BIT 9
`define AWD_CHAN_LSB 10
`define AWD_NEG_BIT 12
`define AWD_OP3_LSB 13
`define AWD_ORDER_LSB 18
`define AWD_DST_LSB 21
`define AWD_DREL_BIT 28
`define AWD_DCHAN_LSB 29
`define AWD_CLAMP_BIT 31
`define AWD_ABS0_BIT 0
`define AWD_ABS1_BIT 1
`define AWD_MASKUPD_BIT 2
`define AWD_PREDUPD_BIT 3
`define AWD_WMASK_BIT 4
`define AWD_SCALE_LSB 5
`define AWD_OP2_LSB 7

// Low doubleword field positions.
`define AWD_IMODE_LSB 26
`define AWD_PSEL_LSB 29

// Opcodes and special select codes.
`define AWD_OP3_MIN 5'h04
`define AWD_OP3_SHARED 5'h11
`define AWD_OP3_GAP0 5'h12
`define AWD_OP3_GAP1 5'h13
`define AWD_OP2_ADDRLOAD 11'h0cc
`define AWD_SEL_PRIM 9'h0f1
`define AWD_SEL_PRIM_HI 9'h0f2
`define AWD_SEL_PRIM_LO 9'h0f3
`define AWD_SEL_DBL1_L 9'h0f4
`define AWD_SEL_DBL1_M 9'h0f5
`define AWD_SEL_DBLH_L 9'h0f6
`define AWD_SEL_DBLH_M 9'h0f7
`define AWD_SEL_F0 9'h0f8
`define AWD_SEL_F1 9'h0f9
`define AWD_SEL_I1 9'h0fa
`define AWD_SEL_IM1 9'h0fb
`define AWD_SEL_FH 9'h0fc
`define AWD_SEL_LIT 9'h0fd
`define AWD_SEL_PV 9'h0fe

// Constant operand values.
`define AWD_K_DBL1_L 32'h00000000
`define AWD_K_DBL1_M 32'h3ff00000
`define AWD_K_DBLH_L 32'h00000000
`define AWD_K_DBLH_M 32'h3fe00000
`define AWD_K_F0 32'h00000000
`define AWD_K_F1 32'h3f800000
`define AWD_K_I1 32'h00000001
`define AWD_K_IM1 32'hffffffff
`define AWD_K_FH 32'h3f000000

// Relative index modes.
`define AWD_IMODE_ARX 3'h0
`define AWD_IMODE_LOOP 3'h4
`define AWD_IMODE_GLOBAL 3'h5
`define AWD_IMODE_GLOBAL_ARX 3'h6

`endif

/* File: verilog/awd_decoder.v */
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "awd_defs.vh"

module awd_decoder #(
  parameter QUADS = 16
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [QUADS-1:1] i_prim_start_mask,
  input wire [31:0] i_prim_expand_hi,
  input wire [31:0] i_prim_expand_lo,
  input wire [8:0] i_address_register_x,
  input wire [8:0] i_loop_index,
  input wire [31:0] i_previous_result_x,
  input wire [31:0] i_previous_result_y,
  input wire [31:0] i_previous_result_z,
  input wire [31:0] i_previous_result_w,
  input wire [31:0] i_result_value,
  input wire i_predicate_result,
  input wire [4:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [4:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [8:0] o_address_register_x,
  output reg [8:0] o_flow_program_counter,
  output reg [8:0] o_flow_index_zero,
  output reg [8:0] o_flow_index_one,
  output reg [31:0] o_clause_global,
  output reg o_stored_predicate,
  output reg o_thread_active,
  output reg [1:0] o_thread_hold
);

  // ****************************************************************
  // Register file over AXI4-Lite.
  // ****************************************************************
  reg [1:0] fmt;
  reg [31:0] word0;
  reg [31:0] word1;
  reg [31:0] literal;
  reg [31:0] operand;
  reg [31:0] fields;
  reg illegal;
  reg shared_layout;
  reg aw_held;
  reg w_held;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg go;
  reg [31:0] next_word;
  reg [31:0] cur_word;
  integer b;

  wire aw_take = i_s_axi_awvalid && o_s_axi_awready;
  wire w_take = i_s_axi_wvalid && o_s_axi_wready;
  wire wr_fire = aw_held && w_held && !o_s_axi_bvalid;
  wire wr_hit = (aw_addr == `AWD_REG_CTRL) || (aw_addr == `AWD_REG_WORD0) ||
                (aw_addr == `AWD_REG_WORD1) || (aw_addr == `AWD_REG_LITERAL);

  // Selects the current value of the addressed writable register.
  always @* begin
    case (aw_addr)
      `AWD_REG_CTRL: cur_word = {30'h00000000, fmt};
      `AWD_REG_WORD0: cur_word = word0;
      `AWD_REG_WORD1: cur_word = word1;
      default: cur_word = literal;
    endcase
    for (b = 0; b < 4; b = b + 1) begin
      next_word[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : cur_word[b*8 +: 8];
    end
  end

  // Accepts address and data in either order, then answers once both are held.
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready <= 1'b1;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'h0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      fmt <= `AWD_FMT_OP3;
      word0 <= 32'h00000000;
      word1 <= 32'h00000000;
      literal <= 32'h00000000;
      go <= 1'b0;
    end else begin
      go <= 1'b0;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {i_s_axi_awaddr[4:2], 2'h0};
        o_s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        case (aw_addr)
          `AWD_REG_CTRL: begin
            fmt <= next_word[1:0];
            go <= w_strb[0] && w_data[`AWD_CTRL_GO_BIT];
          end
          `AWD_REG_WORD0: word0 <= next_word;
          `AWD_REG_WORD1: word1 <= next_word;
          `AWD_REG_LITERAL: literal <= next_word;
          default: ;
        endcase
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  // Answers reads one cycle after the address is taken.
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= 2'h0;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp <= 2'h0;
      case ({i_s_axi_araddr[4:2], 2'h0})
        `AWD_REG_CTRL: o_s_axi_rdata <= {30'h00000000, fmt};
        `AWD_REG_WORD0: o_s_axi_rdata <= word0;
        `AWD_REG_WORD1: o_s_axi_rdata <= word1;
        `AWD_REG_STAT: o_s_axi_rdata <= {29'h00000000, o_stored_predicate, shared_layout,
                                         illegal};
        `AWD_REG_FIELDS: o_s_axi_rdata <= fields;
        `AWD_REG_OPERAND: o_s_axi_rdata <= operand;
        `AWD_REG_LITERAL: o_s_axi_rdata <= literal;
        default: begin
          o_s_axi_rdata <= 32'h00000000;
          o_s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Field extraction.
  // ****************************************************************
  wire [8:0] third_source_select = word1[`AWD_SEL_MSB:0];
  wire third_source_relative = word1[`AWD_REL_BIT];
  wire [1:0] third_source_channel = word1[`AWD_CHAN_LSB +: 2];
  wire third_source_negate = word1[`AWD_NEG_BIT];
  wire [4:0] arith_opcode = word1[`AWD_OP3_LSB +: 5];
  wire [2:0] operand_read_order = word1[`AWD_ORDER_LSB +: 3];
  wire [6:0] dest_register_address = word1[`AWD_DST_LSB +: 7];
  wire dest_relative = word1[`AWD_DREL_BIT];
  wire [1:0] dest_channel = word1[`AWD_DCHAN_LSB +: 2];
  wire clamp = word1[`AWD_CLAMP_BIT];
  wire first_source_magnitude = word1[`AWD_ABS0_BIT];
  wire second_source_magnitude = word1[`AWD_ABS1_BIT];
  wire active_mask_update = word1[`AWD_MASKUPD_BIT];
  wire predicate_update = word1[`AWD_PREDUPD_BIT];
  wire write_mask = word1[`AWD_WMASK_BIT];
  wire [1:0] output_scale = word1[`AWD_SCALE_LSB +: 2];
  wire [1:0] thread_deactivate_op = output_scale;
  wire [10:0] address_load_opcode = word1[`AWD_OP2_LSB +: 11];
  wire [6:0] load_destination = dest_register_address;
  wire [2:0] index_mode = word0[`AWD_IMODE_LSB +: 3];
  wire [1:0] predicate_select = word0[`AWD_PSEL_LSB +: 2];

  // Index chosen by the relative-addressing mode; mode 5 adds nothing.
  reg [8:0] rel_index;
  reg mode_bad;
  always @* begin
    mode_bad = 1'b0;
    case (index_mode)
      `AWD_IMODE_ARX: rel_index = i_address_register_x;
      `AWD_IMODE_LOOP: rel_index = i_loop_index;
      `AWD_IMODE_GLOBAL: rel_index = 9'h000;
      `AWD_IMODE_GLOBAL_ARX: rel_index = i_address_register_x;
      default: begin
        rel_index = 9'h000;
        mode_bad = 1'b1;
      end
    endcase
  end

  // Source and destination effective addresses.
  wire [8:0] src_addr = third_source_select + (third_source_relative ? rel_index : 9'h000);
  wire [6:0] dst_addr = dest_register_address +
                        (dest_relative ? rel_index[6:0] : 7'h00);

  // Picks the previous group's result channel.
  reg [31:0] prev_pick;
  always @* begin
    case (third_source_channel)
      2'h0: prev_pick = i_previous_result_x;
      2'h1: prev_pick = i_previous_result_y;
      2'h2: prev_pick = i_previous_result_z;
      default: prev_pick = i_previous_result_w;
    endcase
  end

  // Resolves special select codes to an operand value.
  reg [31:0] raw_operand;
  always @* begin
    case (third_source_select)
      `AWD_SEL_PRIM: raw_operand = {{(32-QUADS){1'b0}}, i_prim_start_mask, 1'b1};
      `AWD_SEL_PRIM_HI: raw_operand = i_prim_expand_hi;
      `AWD_SEL_PRIM_LO: raw_operand = i_prim_expand_lo;
      `AWD_SEL_DBL1_L: raw_operand = `AWD_K_DBL1_L;
      `AWD_SEL_DBL1_M: raw_operand = `AWD_K_DBL1_M;
      `AWD_SEL_DBLH_L: raw_operand = `AWD_K_DBLH_L;
      `AWD_SEL_DBLH_M: raw_operand = `AWD_K_DBLH_M;
      `AWD_SEL_F0: raw_operand = `AWD_K_F0;
      `AWD_SEL_F1: raw_operand = `AWD_K_F1;
      `AWD_SEL_I1: raw_operand = `AWD_K_I1;
      `AWD_SEL_IM1: raw_operand = `AWD_K_IM1;
      `AWD_SEL_FH: raw_operand = `AWD_K_FH;
      `AWD_SEL_LIT: raw_operand = literal;
      `AWD_SEL_PV: raw_operand = prev_pick;
      default: raw_operand = {23'h000000, src_addr};
    endcase
  end

  // Legality checks per format.
  wire op3_bad = (arith_opcode < `AWD_OP3_MIN) || (arith_opcode == `AWD_OP3_GAP0) ||
                 (arith_opcode == `AWD_OP3_GAP1);
  wire order_bad = operand_read_order > 3'h5;
  wire load_bad = (address_load_opcode != `AWD_OP2_ADDRLOAD) || active_mask_update ||
                  (load_destination > 7'h07);
  wire exec_bad = !active_mask_update;
  wire psel_bad = predicate_select == 2'h1;
  reg next_illegal;
  always @* begin
    case (fmt)
      `AWD_FMT_OP3: next_illegal = op3_bad;
      `AWD_FMT_LOAD: next_illegal = load_bad;
      `AWD_FMT_EXEC: next_illegal = exec_bad;
      default: next_illegal = 1'b1;
    endcase
    next_illegal = next_illegal | order_bad | psel_bad |
                   ((third_source_relative | dest_relative) & mode_bad);
  end

  // Thread runs when predicate select admits it.
  wire selected = (predicate_select == 2'h0) ||
                  (predicate_select == 2'h2 && !o_stored_predicate) ||
                  (predicate_select == 2'h3 && o_stored_predicate);

  // ****************************************************************
  // Issue on the go pulse: capture fields and apply state effects.
  // ****************************************************************
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      illegal <= 1'b0;
      shared_layout <= 1'b0;
      operand <= 32'h00000000;
      fields <= 32'h00000000;
      o_address_register_x <= 9'h000;
      o_flow_program_counter <= 9'h000;
      o_flow_index_zero <= 9'h000;
      o_flow_index_one <= 9'h000;
      o_clause_global <= 32'h00000000;
      o_stored_predicate <= 1'b0;
      o_thread_active <= 1'b1;
      o_thread_hold <= 2'h0;
    end else if (go) begin
      illegal <= next_illegal;
      shared_layout <= (fmt == `AWD_FMT_OP3) && (arith_opcode == `AWD_OP3_SHARED);
      operand <= third_source_negate ? {~raw_operand[31], raw_operand[30:0]} :
                 raw_operand;
      // Packed view: write enable, destination, channel, clamp, scale, magnitudes.
      fields <= {17'h00000, first_source_magnitude, second_source_magnitude,
                 clamp, output_scale,
                 write_mask && !next_illegal, dest_channel, dst_addr};
      if (predicate_update && !next_illegal) begin
        o_stored_predicate <= i_predicate_result;
      end
      if (fmt == `AWD_FMT_LOAD && !next_illegal && write_mask) begin
        case (load_destination[2:0])
          3'h0: o_address_register_x <= i_result_value[8:0];
          3'h1: o_flow_program_counter <= i_result_value[8:0];
          3'h2: o_flow_index_zero <= i_result_value[8:0];
          3'h3: o_flow_index_one <= i_result_value[8:0];
          3'h4: o_clause_global[7:0] <= i_result_value[7:0];
          3'h5: o_clause_global[15:8] <= i_result_value[7:0];
          3'h6: o_clause_global[23:16] <= i_result_value[7:0];
          default: o_clause_global[31:24] <= i_result_value[7:0];
        endcase
      end
      if (fmt == `AWD_FMT_EXEC && !next_illegal) begin
        // Active mask follows the predicate after the instruction.
        if (!selected || !(predicate_update ? i_predicate_result : o_stored_predicate)) begin
          o_thread_active <= 1'b0;
          o_thread_hold <= thread_deactivate_op;
        end else begin
          o_thread_active <= 1'b1;
          o_thread_hold <= 2'h0;
        end
      end
    end
  end

endmodule

/* File: sim/awd_checker_assertions.sv */
`timescale 1ns/1ps
// ****************************************
// Bus handshake, destination and thread hold checks
// ****************************************
module awd_checker (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_s_axi_arvalid,
  input wire i_s_axi_bready,
  input wire i_s_axi_rready,
  input wire o_s_axi_awready,
  input wire o_s_axi_bvalid,
  input wire [1:0] o_s_axi_bresp,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  input wire [8:0] o_address_register_x,
  input wire [8:0] o_flow_program_counter,
  input wire [8:0] o_flow_index_zero,
  input wire [8:0] o_flow_index_one,
  input wire [31:0] o_clause_global,
  input wire o_thread_active,
  input wire [1:0] o_thread_hold
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Last clause-global value, so the bytes touched by one load can be counted.
  reg [31:0] prev_cg;
  always @(posedge i_mclk) begin
    prev_cg <= o_clause_global;
  end
  wire [31:0] cg_diff = prev_cg ^ o_clause_global;
  sequence ar_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  wr_resp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
  rd_answer_a: assert property (ar_take |=> o_s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
    else $error("read data dropped");
  rd_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read overlap");
  wr_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready) else $error("write overlap");
  wr_code_a: assert property (o_s_axi_bvalid |-> o_s_axi_bresp == 2'h0 || o_s_axi_bresp == 2'h2)
    else $error("bad write response");
  one_dest_a: assert property ($countones({$changed(o_address_register_x),
    $changed(o_flow_program_counter), $changed(o_flow_index_zero),
    $changed(o_flow_index_one), $changed(o_clause_global)}) <= 1) else $error("two targets");
  cg_byte_a: assert property ($countones({|cg_diff[31:24], |cg_diff[23:16],
    |cg_diff[15:8], |cg_diff[7:0]}) <= 1) else $error("clause global wide write");
  hold_idle_a: assert property (o_thread_hold != 2'h0 |-> !o_thread_active)
    else $error("held thread active");
endmodule

bind awd_decoder awd_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_s_axi_arvalid(i_s_axi_arvalid), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_rready(i_s_axi_rready), .o_s_axi_awready(o_s_axi_awready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_bresp(o_s_axi_bresp),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
  .o_address_register_x(o_address_register_x), .o_flow_program_counter(o_flow_program_counter),
  .o_flow_index_zero(o_flow_index_zero), .o_flow_index_one(o_flow_index_one),
  .o_clause_global(o_clause_global), .o_thread_active(o_thread_active),
  .o_thread_hold(o_thread_hold));

/* File: sim/awd_seq_model.sv */
`timescale 1ns/1ps
// ****************************************
// Clause sequencer stand-in
// ****************************************
module awd_seq_model #(
  parameter [14:0] PMASK = 15'h0001,
  parameter [31:0] EXP_HI = 32'h0,
  parameter [31:0] EXP_LO = 32'h0,
  parameter [31:0] PREV = 32'h0,
  parameter [8:0] ARX = 9'h0,
  parameter [8:0] LOOP = 9'h0
) (
  input wire i_mclk,
  input wire [31:0] i_res_cmd,
  input wire i_pred_cmd,
  output wire [14:0] o_prim_start_mask,
  output wire [31:0] o_prim_expand_hi,
  output wire [31:0] o_prim_expand_lo,
  output wire [8:0] o_arx,
  output wire [8:0] o_loop,
  output wire [31:0] o_prev_x,
  output wire [31:0] o_prev_y,
  output wire [31:0] o_prev_z,
  output wire [31:0] o_prev_w,
  output reg [31:0] o_result_value = 32'h0,
  output reg o_predicate_result = 1'b0
);
  // The first quad always starts a primitive, so its bit is never sent.
  assign o_prim_start_mask = PMASK;
  assign o_prim_expand_hi = EXP_HI;
  assign o_prim_expand_lo = EXP_LO;
  assign o_arx = ARX;
  assign o_loop = LOOP;
  // Each channel of the previous group carries a distinct value.
  assign o_prev_x = PREV;
  assign o_prev_y = PREV + 32'h1;
  assign o_prev_z = PREV + 32'h2;
  assign o_prev_w = PREV + 32'h3;
  // Results and predicates change only just after a clock edge.
  always @(posedge i_mclk) begin
    o_result_value <= i_res_cmd;
    o_predicate_result <= i_pred_cmd;
  end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
// ****************************************
// Register-driven decoder bench
// ****************************************
module tb;
  localparam [14:0] PM = 15'h2a5a;
  localparam [31:0] EH = 32'h13579bdf;
  localparam [31:0] EL = 32'h2468ace0;
  localparam [31:0] PV = 32'h40400000;
  localparam [8:0] AX = 9'h013;
  localparam [8:0] LP = 9'h021;
  localparam [31:0] KC [0:8] = '{32'h0, 32'h3ff00000, 32'h0, 32'h3fe00000,
    32'h0, 32'h3f800000, 32'h1, 32'hffffffff, 32'h3f000000};
  reg i_mclk = 1'b0;
  reg i_rst_n = 1'b0;
  reg [31:0] res = 32'h0;
  reg pred = 1'b0;
  reg [4:0] awaddr = 5'h00;
  reg [3:0] ws = 4'hf;
  reg [4:0] araddr = 5'h0;
  reg [31:0] wdata = 32'h0;
  reg awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  wire awr, wrdy, bv, arr, rv, sp, act, pr;
  wire [1:0] br, rr, hold;
  wire [31:0] rd, cg, rval, eh, el, px, py, pz, pw;
  wire [8:0] ax, pc, i0, i1, arx, lpi;
  wire [14:0] pm;
  reg [31:0] v, ecg;
  reg [8:0] v9;
  reg [1:0] r;
  integer k, n_fail = 0, tests_run = 0;

  always #10 i_mclk = ~i_mclk;

  awd_seq_model #(.PMASK(PM), .EXP_HI(EH), .EXP_LO(EL), .PREV(PV), .ARX(AX), .LOOP(LP)) u_seq (
    .i_mclk(i_mclk), .i_res_cmd(res), .i_pred_cmd(pred), .o_prim_start_mask(pm),
    .o_prim_expand_hi(eh), .o_prim_expand_lo(el), .o_arx(arx), .o_loop(lpi), .o_prev_x(px),
    .o_prev_y(py), .o_prev_z(pz), .o_prev_w(pw), .o_result_value(rval),
    .o_predicate_result(pr));
  awd_decoder #(.QUADS(16)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_prim_start_mask(pm),
    .i_prim_expand_hi(eh), .i_prim_expand_lo(el), .i_address_register_x(arx),
    .i_loop_index(lpi), .i_previous_result_x(px), .i_previous_result_y(py),
    .i_previous_result_z(pz), .i_previous_result_w(pw), .i_result_value(rval),
    .i_predicate_result(pr), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrdy), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rready),
    .o_address_register_x(ax), .o_flow_program_counter(pc), .o_flow_index_zero(i0),
    .o_flow_index_one(i1), .o_clause_global(cg), .o_stored_predicate(sp),
    .o_thread_active(act), .o_thread_hold(hold));

  // Compares one value and counts the outcome.
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One bus write; channels are released at the edge that takes them.
  task wr(input [4:0] a, input [31:0] d, output [1:0] resp);
    reg ta, tw, tk;
    begin
      @(posedge i_mclk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      tk = 1'b0;
      while (!tk) begin
        @(negedge i_mclk);
        ta = awv & awr;
        tw = wv & wrdy;
        tk = bv;
        resp = br;
        @(posedge i_mclk);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
      end
      bready <= 1'b0;
    end
  endtask

  // One bus read; data is taken at the edge where rvalid is seen.
  task rdr(input [4:0] a, output [31:0] d);
    reg ta, tk;
    begin
      @(posedge i_mclk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      tk = 1'b0;
      while (!tk) begin
        @(negedge i_mclk);
        ta = arv & arr;
        tk = rv;
        d = rd;
        @(posedge i_mclk);
        if (ta) arv <= 1'b0;
      end
      rready <= 1'b0;
    end
  endtask

  // Loads both words, issues the decode and waits out the result latency.
  task iss(input [1:0] f, input [31:0] w0, input [31:0] w1);
    begin
      wr(5'h04, w0, r);
      wr(5'h08, w1, r);
      wr(5'h00, {29'h0, 1'b1, f}, r);
      repeat (3) @(posedge i_mclk);
    end
  endtask

  // Issues an instruction and compares a masked register.
  task ichk(input [1:0] f, input [31:0] w0, input [31:0] w1, input [4:0] a, input [31:0] m,
    input [31:0] exp);
    begin
      iss(f, w0, w1);
      rdr(a, v);
      chk(v & m, exp);
    end
  endtask

  // Holds reset low for four cycles.
  task rst;
    begin
      i_rst_n <= 1'b0;
      repeat (4) @(posedge i_mclk);
      i_rst_n <= 1'b1;
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task summarize;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  // Cuts a hang short.
  initial begin
    #200000;
    n_fail = n_fail + 1;
    summarize;
  end

  // Main sequence.
  initial begin
    ecg = 32'h0;
    rst;
    chk(act, 1'b1);
    rdr(5'h0c, v);
    chk(v, 32'h0);
    wr(5'h0c, 32'h1, r);
    chk(r, 2'h2);
    ichk(0, 0, 32'h280f1, 5'h14, 32'hffffffff, {16'h0, PM, 1'b1});
    ichk(0, 0, 32'h280f2, 5'h14, 32'hffffffff, EH);
    ichk(0, 0, 32'h280f3, 5'h14, 32'hffffffff, EL);
    for (k = 0; k < 9; k = k + 1) begin
      ichk(0, 0, 32'h280f4 + k, 5'h14, 32'hffffffff, KC[k]);
    end
    wr(5'h18, 32'hcafe0123, r);
    chk(r, 2'h0);
    ws <= 4'h1;
    wr(5'h18, 32'h000000ff, r);
    ws <= 4'hf;
    ichk(0, 0, 32'h280fd, 5'h14, 32'hffffffff, 32'hcafe01ff);
    for (k = 0; k < 4; k = k + 1) begin
      ichk(0, 0, 32'h280fe | (k << 10), 5'h14, 32'hffffffff, PV + k);
    end
    ichk(0, 0, 32'h290f9, 5'h14, 32'hffffffff, 32'hbf800000);
    ichk(0, 32'h10000000, 32'h28010, 5'h14, 32'hffffffff, 32'h10);
    ichk(0, 32'h00000000, 32'h28210, 5'h14, 32'hffffffff, 32'h10 + AX);
    ichk(0, 32'h10000000, 32'h28210, 5'h14, 32'hffffffff, 32'h10 + LP);
    ichk(0, 32'h14000000, 32'h28210, 5'h14, 32'hffffffff, 32'h10);
    ichk(0, 32'h18000000, 32'h28210, 5'h14, 32'hffffffff, 32'h10 + AX);
    ichk(0, 0, 32'hcab68010, 5'h10, 32'h13ff, 32'h1355);
    ichk(0, 32'h10000000, 32'h1e028000, 5'h10, 32'h7f, 32'h11);
    ichk(0, 0, 32'h8000, 5'h0c, 32'h3, 32'h0);
    ichk(0, 0, 32'h22000, 5'h0c, 32'h3, 32'h2);
    ichk(0, 0, 32'h3e000, 5'h0c, 32'h3, 32'h0);
    for (k = 0; k < 8; k = k + 1) begin
      v9 = 9'h100 | (k * 8'h23);
      res <= {23'h0, v9};
      ichk(1, 0, 32'h6613 | (k << 21) | (k[1:0] << 5), 5'h10, 32'h6c00,
        32'h6000 | (k[1:0] << 10));
      if (k > 3) ecg[8 * (k - 4) +: 8] = v9[7:0];
      case (k)
        0: chk(ax, v9);
        1: chk(pc, v9);
        2: chk(i0, v9);
        3: chk(i1, v9);
        default: chk(cg, ecg);
      endcase
    end
    res <= 32'h1ff;
    ichk(1, 0, 32'h6690, 5'h0c, 32'h1, 32'h1);
    chk(ax, 9'h100);
    ichk(0, 0, 32'h6000, 5'h0c, 32'h1, 32'h1);
    ichk(0, 0, 32'h24000, 5'h0c, 32'h1, 32'h1);
    ichk(0, 0, 32'h26000, 5'h0c, 32'h1, 32'h1);
    ichk(0, 0, 32'h1a8000, 5'h0c, 32'h1, 32'h1);
    ichk(0, 32'h20000000, 32'h28000, 5'h0c, 32'h1, 32'h1);
    ichk(1, 0, 32'h26600, 5'h0c, 32'h1, 32'h1);
    ichk(1, 0, 32'h6604, 5'h0c, 32'h1, 32'h1);
    ichk(1, 0, 32'h1006600, 5'h0c, 32'h1, 32'h1);
    ichk(2, 0, 32'h0, 5'h0c, 32'h1, 32'h1);
    pred <= 1'b1;
    iss(2, 0, 32'hc);
    chk({sp, act}, 2'h3);
    pred <= 1'b0;
    iss(2, 0, 32'h4);
    chk({sp, act}, 2'h3);
    for (k = 0; k < 4; k = k + 1) begin
      rst;
      pred <= 1'b1;
      iss(2, 0, 32'hc);
      iss(2, 32'h40000000, 32'h4 | (k << 5));
      chk(act, 1'b0);
      if (k == 1 || k == 2) chk(hold, k[1:0]);
    end
    summarize;
  end
endmodule
